// File: papf_pkg.sv
package papf_pkg;

    // pin configuration field encodings (4 bits per pin)
    localparam logic [3:0] PAPF_CFG_ANALOG = 4'h0;
    localparam logic [3:0] PAPF_CFG_OUT_PP = 4'h1;
    localparam logic [3:0] PAPF_CFG_IN_FLOAT = 4'h4;
    localparam logic [3:0] PAPF_CFG_OUT_OD = 4'h5;
    localparam logic [3:0] PAPF_CFG_IN_PULL = 4'h8;
    localparam logic [3:0] PAPF_CFG_ALT_PP = 4'h9;
    localparam logic [3:0] PAPF_CFG_ALT_OD = 4'hd;
    localparam int PAPF_CFG_W = 4;

    // field positions inside the low and high pin config words
    localparam int PAPF_CFGL_P2_LSB = 8;
    localparam int PAPF_CFGL_P3_LSB = 12;
    localparam int PAPF_CFGH_P4_LSB = 0;
    localparam int PAPF_CFGH_P5_LSB = 4;
    localparam int PAPF_CFGH_P6_LSB = 8;

    // timer remap and channel output enable bit positions
    localparam int PAPF_REMAP_CH2_BIT = 5;
    localparam int PAPF_REMAP_CH4_BIT = 7;
    localparam int PAPF_CCER_CH2_BIT = 1;
    localparam int PAPF_CCER_CH3_BIT = 2;
    localparam int PAPF_CCER_CH4_BIT = 3;

    // serial controller 2 mode and spi master bit
    localparam logic [1:0] PAPF_SC_OFF = 2'h0;
    localparam logic [1:0] PAPF_SC_UART = 2'h1;
    localparam logic [1:0] PAPF_SC_SPI = 2'h2;
    localparam logic [1:0] PAPF_SC_TWI = 2'h3;
    localparam int PAPF_SPI_MASTER_BIT = 4;

    // pad indices: bit 0 is pin 2 ... bit 4 is pin 6
    localparam int PAPF_NPINS = 5;
    localparam int PAPF_P2 = 0;
    localparam int PAPF_P3 = 1;
    localparam int PAPF_P4 = 2;
    localparam int PAPF_P5 = 3;
    localparam int PAPF_P6 = 4;

    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
        logic [4:0] analog;
    } papf_pads_t;

    typedef struct packed {
        logic tim2_ch4;
        logic tim2_ch2;
        logic tim1_ch3;
        logic twi_clk;
        logic spi_clk;
        logic ssel_n;
        logic [4:0] gpio;
    } papf_caps_t;

    typedef struct packed {
        papf_pads_t pads;
        papf_caps_t caps;
        logic [1:0] portb_tim_oe;
        logic strap_pending;
        logic factory_boot;
    } papf_state_t;

    localparam papf_pads_t PAPF_PADS_RST = '{out: 5'h00, oe: 5'h00, analog: 5'h00};
    localparam papf_caps_t PAPF_CAPS_RST = '{tim2_ch4: 1'b0, tim2_ch2: 1'b0, tim1_ch3: 1'b0,
        twi_clk: 1'b1, spi_clk: 1'b0, ssel_n: 1'b1, gpio: 5'h00};
    localparam papf_state_t PAPF_STATE_RST = '{pads: PAPF_PADS_RST, caps: PAPF_CAPS_RST,
        portb_tim_oe: 2'h0, strap_pending: 1'b0, factory_boot: 1'b0};

endpackage : papf_pkg

// File: papf_pad_cell.sv
`timescale 1ns/1ps
// resolves one pad from its config field: gpio, alternate push-pull,
// alternate open-drain or analog
module papf_pad_cell
    import papf_pkg::*;
(
    input wire logic [3:0] cfg,
    input wire logic alt_on,
    input wire logic alt_val,
    input wire logic gpio_out,
    input wire logic hold_input,
    output logic pad_out,
    output logic pad_oe,
    output logic pad_analog
);

    // open-drain drives low only; a released pad takes whatever level the board gives it
    always_comb begin
        pad_out = 1'b0;
        pad_oe = 1'b0;
        pad_analog = 1'b0;
        case (cfg)
            PAPF_CFG_ANALOG: begin
                pad_analog = 1'b1;
            end
            PAPF_CFG_OUT_PP: begin
                pad_out = gpio_out;
                pad_oe = 1'b1;
            end
            PAPF_CFG_OUT_OD: begin
                pad_oe = ~gpio_out;
            end
            PAPF_CFG_ALT_PP: begin
                // no owner: fall back to plain gpio output
                pad_out = alt_on ? alt_val : gpio_out;
                pad_oe = 1'b1;
            end
            PAPF_CFG_ALT_OD: begin
                pad_oe = alt_on ? ~alt_val : ~gpio_out;
            end
            default: begin
                pad_oe = 1'b0; // input modes
            end
        endcase
        // strap sampling window keeps the pad released
        if (hold_input) begin
            pad_oe = 1'b0;
        end
    end

endmodule : papf_pad_cell

// File: papf_pin_mux.sv
`timescale 1ns/1ps
module papf_pin_mux
    import papf_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic external_reset_n,
    input wire logic [7:0] second_timer_option_remap,
    input wire logic [3:0] second_timer_channel_output_enable,
    input wire logic [3:0] first_timer_channel_output_enable,
    input wire logic [15:0] port_a_low_pin_config,
    input wire logic [15:0] port_a_high_pin_config,
    input wire logic [1:0] serial_two_mode_select,
    input wire logic [7:0] serial_two_spi_config,
    input wire logic trace_enable,
    input wire logic trace_four_wire,
    input wire logic packet_trace_enable,
    input wire logic second_timer_channel_four_out,
    input wire logic second_timer_channel_two_out,
    input wire logic first_timer_channel_three_out,
    input wire logic serial_two_twowire_clock_out,
    input wire logic serial_two_spi_clock_out,
    input wire logic cpu_trace_clock,
    input wire logic cpu_trace_data_two,
    input wire logic cpu_trace_data_three,
    input wire logic packet_trace_frame,
    input wire logic packet_trace_serial_out,
    input wire logic [4:0] gpio_out,
    input wire logic [4:0] port_a_in,
    input wire logic port_b_pin_two_in,
    input wire logic port_b_pin_four_in,
    output papf_pads_t port_a_pads,
    output papf_caps_t captures,
    output logic [1:0] port_b_timer_oe,
    output logic factory_monitor_boot
);

    papf_state_t st_r;
    papf_state_t st_nxt;

    logic [3:0] cfg_p2;
    logic [3:0] cfg_p3;
    logic [3:0] cfg_p4;
    logic [3:0] cfg_p5;
    logic [3:0] cfg_p6;
    logic spi_mode;
    logic twi_mode;
    logic spi_master;
    logic ch4_owns;
    logic ch2_owns;
    logic [4:0] alt_on;
    logic [4:0] alt_val;
    logic [4:0] hold;
    logic [19:0] cfg_all;
    logic [4:0] pad_out_c;
    logic [4:0] pad_oe_c;
    logic [4:0] pad_an_c;

    // config fields per pin
    assign cfg_p2 = port_a_low_pin_config[PAPF_CFGL_P2_LSB +: PAPF_CFG_W];
    assign cfg_p3 = port_a_low_pin_config[PAPF_CFGL_P3_LSB +: PAPF_CFG_W];
    assign cfg_p4 = port_a_high_pin_config[PAPF_CFGH_P4_LSB +: PAPF_CFG_W];
    assign cfg_p5 = port_a_high_pin_config[PAPF_CFGH_P5_LSB +: PAPF_CFG_W];
    assign cfg_p6 = port_a_high_pin_config[PAPF_CFGH_P6_LSB +: PAPF_CFG_W];
    assign cfg_all = {cfg_p6, cfg_p5, cfg_p4, cfg_p3, cfg_p2};

    // serial controller 2 and timer ownership terms
    assign spi_mode = (serial_two_mode_select == PAPF_SC_SPI);
    assign twi_mode = (serial_two_mode_select == PAPF_SC_TWI);
    assign spi_master = serial_two_spi_config[PAPF_SPI_MASTER_BIT];
    assign ch4_owns = ~second_timer_option_remap[PAPF_REMAP_CH4_BIT]
        & second_timer_channel_output_enable[PAPF_CCER_CH4_BIT];
    assign ch2_owns = ~second_timer_option_remap[PAPF_REMAP_CH2_BIT]
        & second_timer_channel_output_enable[PAPF_CCER_CH2_BIT];

    // alternate source select; a live timer output wins the pad over others
    always_comb begin
        alt_on = 5'h00;
        alt_val = 5'h00;
        hold = 5'h00;
        // pin 2
        if (ch4_owns && cfg_p2 == PAPF_CFG_ALT_PP) begin
            alt_on[PAPF_P2] = 1'b1;
            alt_val[PAPF_P2] = second_timer_channel_four_out;
        end else if (!ch4_owns && twi_mode && cfg_p2 == PAPF_CFG_ALT_OD) begin
            alt_on[PAPF_P2] = 1'b1;
            alt_val[PAPF_P2] = serial_two_twowire_clock_out;
        end else if (!ch4_owns && spi_mode && spi_master && cfg_p2 == PAPF_CFG_ALT_PP) begin
            alt_on[PAPF_P2] = 1'b1;
            alt_val[PAPF_P2] = serial_two_spi_clock_out;
        end
        // pin 3
        if (ch2_owns && cfg_p3 == PAPF_CFG_ALT_PP) begin
            alt_on[PAPF_P3] = 1'b1;
            alt_val[PAPF_P3] = second_timer_channel_two_out;
        end else if (!ch2_owns && trace_enable && cfg_p3 == PAPF_CFG_ALT_PP) begin
            alt_on[PAPF_P3] = 1'b1;
            alt_val[PAPF_P3] = cpu_trace_clock;
        end
        // pin 4: core trace has priority over packet trace
        if (trace_enable && trace_four_wire) begin
            alt_on[PAPF_P4] = 1'b1;
            alt_val[PAPF_P4] = cpu_trace_data_two;
        end else if (!trace_enable && packet_trace_enable) begin
            alt_on[PAPF_P4] = 1'b1;
            alt_val[PAPF_P4] = packet_trace_frame;
        end
        // pin 5
        if (trace_enable && trace_four_wire) begin
            alt_on[PAPF_P5] = 1'b1;
            alt_val[PAPF_P5] = cpu_trace_data_three;
        end else if (!trace_enable && packet_trace_enable) begin
            alt_on[PAPF_P5] = 1'b1;
            alt_val[PAPF_P5] = packet_trace_serial_out;
        end
        // strap must read the board level, so pin 5 is released meanwhile
        hold[PAPF_P5] = ~external_reset_n | st_r.strap_pending;
        // pin 6
        if (first_timer_channel_output_enable[PAPF_CCER_CH3_BIT]) begin
            alt_on[PAPF_P6] = 1'b1;
            alt_val[PAPF_P6] = first_timer_channel_three_out;
        end
    end

    // one pad resolver per pin
    genvar gi;
    generate
        for (gi = 0; gi < PAPF_NPINS; gi = gi + 1) begin : g_pad
            papf_pad_cell u_cell (
                .cfg(cfg_all[gi*PAPF_CFG_W +: PAPF_CFG_W]),
                .alt_on(alt_on[gi]),
                .alt_val(alt_val[gi]),
                .gpio_out(gpio_out[gi]),
                .hold_input(hold[gi]),
                .pad_out(pad_out_c[gi]),
                .pad_oe(pad_oe_c[gi]),
                .pad_analog(pad_an_c[gi])
            );
        end
    endgenerate

    // next state; every path goes through one register stage, so pads and
    // captures lag their sources by one clock
    always_comb begin
        st_nxt = st_r;
        st_nxt.pads.out = pad_out_c;
        st_nxt.pads.oe = pad_oe_c;
        // only pins 4 and 5 have analog inputs behind them
        st_nxt.pads.analog = 5'h00;
        st_nxt.pads.analog[PAPF_P4] = pad_an_c[PAPF_P4];
        st_nxt.pads.analog[PAPF_P5] = pad_an_c[PAPF_P5];
        // capture routing with port b remap
        st_nxt.caps.tim2_ch4 = second_timer_option_remap[PAPF_REMAP_CH4_BIT]
            ? port_b_pin_four_in : port_a_in[PAPF_P2];
        st_nxt.caps.tim2_ch2 = second_timer_option_remap[PAPF_REMAP_CH2_BIT]
            ? port_b_pin_two_in : port_a_in[PAPF_P3];
        st_nxt.caps.tim1_ch3 = port_a_in[PAPF_P6];
        // two-wire clock line reads the pad so clock stretching is seen
        st_nxt.caps.twi_clk = twi_mode ? port_a_in[PAPF_P2] : 1'b1;
        st_nxt.caps.spi_clk = (spi_mode && !spi_master) ? port_a_in[PAPF_P2] : 1'b0;
        st_nxt.caps.ssel_n = (spi_mode && !spi_master) ? port_a_in[PAPF_P3] : 1'b1;
        st_nxt.caps.gpio = port_a_in;
        // remapped timer outputs are offered to port b
        st_nxt.portb_tim_oe[0] = second_timer_option_remap[PAPF_REMAP_CH2_BIT]
            & second_timer_channel_output_enable[PAPF_CCER_CH2_BIT];
        st_nxt.portb_tim_oe[1] = second_timer_option_remap[PAPF_REMAP_CH4_BIT]
            & second_timer_channel_output_enable[PAPF_CCER_CH4_BIT];
        // strap: sample through reset and once more just after release
        if (!external_reset_n) begin
            st_nxt.factory_boot = ~port_a_in[PAPF_P5];
            st_nxt.strap_pending = 1'b1;
        end else if (st_r.strap_pending) begin
            st_nxt.factory_boot = ~port_a_in[PAPF_P5];
            st_nxt.strap_pending = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= PAPF_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign port_a_pads = st_r.pads;
    assign captures = st_r.caps;
    assign port_b_timer_oe = st_r.portb_tim_oe;
    assign factory_monitor_boot = st_r.factory_boot;

    // checks on the registered pads against the raw controls one clock earlier
    a_pin2_timer_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!second_timer_option_remap[7] && second_timer_channel_output_enable[3]
        && port_a_low_pin_config[11:8] == 4'h9)
        |=> (port_a_pads.oe[0] && port_a_pads.out[0] == $past(second_timer_channel_four_out)))
        else $error("pin 2 does not carry timer2 ch4");

    a_ch4_capture_src: assert property (@(posedge clk) disable iff (sys_rst)
        !second_timer_option_remap[7] |=> captures.tim2_ch4 == $past(port_a_in[0]))
        else $error("timer2 ch4 capture not from pin 2");

    a_twi_open_drain: assert property (@(posedge clk) disable iff (sys_rst)
        (serial_two_mode_select == 2'h3 && port_a_low_pin_config[11:8] == 4'hd
        && second_timer_option_remap[7])
        |=> (!port_a_pads.out[0] && port_a_pads.oe[0] == !$past(serial_two_twowire_clock_out)))
        else $error("two-wire clock not open-drain on pin 2");

    a_spi_master_clk: assert property (@(posedge clk) disable iff (sys_rst)
        (serial_two_mode_select == 2'h2 && serial_two_spi_config[4]
        && port_a_low_pin_config[11:8] == 4'h9 && !second_timer_channel_output_enable[3])
        |=> port_a_pads.oe[0] && port_a_pads.out[0] == $past(serial_two_spi_clock_out))
        else $error("spi master clock missing on pin 2");

    a_slave_select_in: assert property (@(posedge clk) disable iff (sys_rst)
        (serial_two_mode_select == 2'h2 && !serial_two_spi_config[4])
        |=> captures.ssel_n == $past(port_a_in[1]) && captures.spi_clk == $past(port_a_in[0]))
        else $error("spi slave inputs not routed");

    a_trace_clk_out: assert property (@(posedge clk) disable iff (sys_rst)
        (trace_enable && second_timer_option_remap[5] && port_a_low_pin_config[15:12] == 4'h9)
        |=> port_a_pads.oe[1] && port_a_pads.out[1] == $past(cpu_trace_clock))
        else $error("trace clock missing on pin 3");

    a_ch2_remap_src: assert property (@(posedge clk) disable iff (sys_rst)
        second_timer_option_remap[5] |=> captures.tim2_ch2 == $past(port_b_pin_two_in))
        else $error("timer2 ch2 capture not from port b");

    a_pti_frame_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!trace_enable && packet_trace_enable && port_a_high_pin_config[3:0] == 4'h9)
        |=> port_a_pads.oe[2] && port_a_pads.out[2] == $past(packet_trace_frame))
        else $error("packet trace frame missing on pin 4");

    a_boot_strap_hold: assert property (@(posedge clk) disable iff (sys_rst)
        ($rose(external_reset_n) && !$past(sys_rst)) |=> !port_a_pads.oe[3]
        ##1 factory_monitor_boot == !$past(port_a_in[3], 2))
        else $error("boot strap not sampled after reset release");

    a_ch3_capture_src: assert property (@(posedge clk) disable iff (sys_rst)
        1'b1 |=> captures.tim1_ch3 == $past(port_a_in[4]))
        else $error("timer1 ch3 capture not from pin 6");

    a_pin3_timer_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!second_timer_option_remap[5] && second_timer_channel_output_enable[1]
        && port_a_low_pin_config[15:12] == 4'h9)
        |=> port_a_pads.oe[1] && port_a_pads.out[1] == $past(second_timer_channel_two_out))
        else $error("pin 3 does not carry timer2 ch2");

    a_ch2_capture_src: assert property (@(posedge clk) disable iff (sys_rst)
        !second_timer_option_remap[5] |=> captures.tim2_ch2 == $past(port_a_in[1]))
        else $error("timer2 ch2 capture not from pin 3");

    a_ch4_remap_src: assert property (@(posedge clk) disable iff (sys_rst)
        second_timer_option_remap[7] |=> captures.tim2_ch4 == $past(port_b_pin_four_in)
        && port_b_timer_oe[1] == $past(second_timer_channel_output_enable[3]))
        else $error("timer2 ch4 not moved to port b");

    a_analog_pin4: assert property (@(posedge clk) disable iff (sys_rst)
        port_a_high_pin_config[3:0] == 4'h0 |=> port_a_pads.analog[2] && !port_a_pads.oe[2])
        else $error("pin 4 not connected to analog input");

    a_analog_pin5: assert property (@(posedge clk) disable iff (sys_rst)
        port_a_high_pin_config[7:4] == 4'h0 |=> port_a_pads.analog[3] && !port_a_pads.oe[3])
        else $error("pin 5 not connected to analog input");

    a_trace_data_two: assert property (@(posedge clk) disable iff (sys_rst)
        (trace_enable && trace_four_wire && port_a_high_pin_config[3:0] == 4'h9)
        |=> port_a_pads.oe[2] && port_a_pads.out[2] == $past(cpu_trace_data_two))
        else $error("trace data bit two missing on pin 4");

    // the strap window releases pin 5, so both checks skip it
    a_trace_data_three: assert property (@(posedge clk) disable iff (sys_rst)
        (trace_enable && trace_four_wire && port_a_high_pin_config[7:4] == 4'h9
        && external_reset_n && $past(external_reset_n))
        |=> port_a_pads.oe[3] && port_a_pads.out[3] == $past(cpu_trace_data_three))
        else $error("trace data bit three missing on pin 5");

    a_packet_trace_serial_out_out: assert property (@(posedge clk) disable iff (sys_rst)
        (!trace_enable && packet_trace_enable && port_a_high_pin_config[7:4] == 4'h9
        && external_reset_n && $past(external_reset_n))
        |=> port_a_pads.oe[3] && port_a_pads.out[3] == $past(packet_trace_serial_out))
        else $error("packet trace data missing on pin 5");

    a_pin6_timer_out: assert property (@(posedge clk) disable iff (sys_rst)
        (first_timer_channel_output_enable[2] && port_a_high_pin_config[11:8] == 4'h9)
        |=> port_a_pads.oe[4] && port_a_pads.out[4] == $past(first_timer_channel_three_out))
        else $error("pin 6 does not carry timer1 ch3");

    a_gpio_fallback: assert property (@(posedge clk) disable iff (sys_rst)
        (port_a_high_pin_config[11:8] == 4'h9 && !first_timer_channel_output_enable[2])
        |=> port_a_pads.oe[4] && port_a_pads.out[4] == $past(gpio_out[4]))
        else $error("pin 6 does not fall back to gpio");

    c_twi_clock: cover property (@(posedge clk) disable iff (sys_rst)
        serial_two_mode_select == 2'h3 && port_a_low_pin_config[11:8] == 4'hd);
    c_trace_four: cover property (@(posedge clk) disable iff (sys_rst)
        trace_enable && trace_four_wire && port_a_high_pin_config[7:0] == 8'h99);
    c_factory_boot: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(factory_monitor_boot));
    c_analog_pins: cover property (@(posedge clk) disable iff (sys_rst)
        port_a_pads.analog[2] && port_a_pads.analog[3]);

endmodule : papf_pin_mux

// File: papf_board.sv
`timescale 1ns/1ps
// board side of port a: pad levels seen by the chip's input buffers
module papf_board
    import papf_pkg::*;
(
    input wire logic clk,
    input wire papf_pads_t pads,
    input wire logic [4:0] drv_en,
    input wire logic [4:0] drv_val,
    output logic [4:0] pad_in
);
    logic [4:0] float_r = 5'h0a;
    // released pads toggle each cycle so a stale level never passes for a driven one
    always @(posedge clk) float_r <= ~float_r;
    // chip driver wins; else the external driver on any pin with drv_en set, else the toggling float level
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pad_in[i] = pads.oe[i] ? pads.out[i] : (drv_en[i] ? drv_val[i] : float_r[i]);
        end
    end
endmodule : papf_board

// File: test_papf_pin_mux.sv
`timescale 1ns/1ps
module test_papf_pin_mux;
    import papf_pkg::*;
    typedef struct packed {
        papf_pads_t p;
        papf_caps_t c;
        logic [1:0] pb;
        logic fmb;
        logic [4:0] m;
    } papf_exp_t;
    localparam logic [3:0] CODES_A [6] = '{4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd};
    localparam logic [3:0] CODES_B [6] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
    logic clk = 1'b0, sys_rst = 1'b1, ext_n = 1'b1;
    logic [7:0] remap = 8'h00, spicfg = 8'h00;
    logic [3:0] ccer2 = 4'h0, ccer1 = 4'h0;
    logic [15:0] cfgl = 16'h0000, cfgh = 16'h0000;
    logic [1:0] mode = 2'h0, pbo;
    logic [2:0] trc = 3'h0;
    logic [9:0] src = 10'h000;
    logic [4:0] gpio = 5'h00, drv_en = 5'h00, drv_val = 5'h00, pa_in;
    logic pb2 = 1'b0, pb4 = 1'b0, fmb, fmb_e = 1'b0, prev_low = 1'b0;
    papf_pads_t pads;
    papf_caps_t caps;
    papf_exp_t q[$];
    papf_exp_t e;
    int bad_count = 0, n_tests = 0, cycles = 0;
    always #50 clk = ~clk;
    papf_pin_mux i_dut (.clk(clk), .sys_rst(sys_rst), .external_reset_n(ext_n),
        .second_timer_option_remap(remap), .second_timer_channel_output_enable(ccer2),
        .first_timer_channel_output_enable(ccer1), .port_a_low_pin_config(cfgl),
        .port_a_high_pin_config(cfgh), .serial_two_mode_select(mode),
        .serial_two_spi_config(spicfg), .trace_enable(trc[0]), .trace_four_wire(trc[1]),
        .packet_trace_enable(trc[2]), .second_timer_channel_four_out(src[0]),
        .second_timer_channel_two_out(src[1]), .first_timer_channel_three_out(src[2]),
        .serial_two_twowire_clock_out(src[3]), .serial_two_spi_clock_out(src[4]),
        .cpu_trace_clock(src[5]), .cpu_trace_data_two(src[6]), .cpu_trace_data_three(src[7]),
        .packet_trace_frame(src[8]), .packet_trace_serial_out(src[9]), .gpio_out(gpio),
        .port_a_in(pa_in), .port_b_pin_two_in(pb2), .port_b_pin_four_in(pb4),
        .port_a_pads(pads), .captures(caps), .port_b_timer_oe(pbo),
        .factory_monitor_boot(fmb));
    papf_board i_board (.clk(clk), .pads(pads), .drv_en(drv_en), .drv_val(drv_val),
        .pad_in(pa_in));
    // one pad from its field: {out, oe, analog}
    function automatic logic [2:0] padf(logic [3:0] c, logic live, logic av, logic g);
        case (c)
            4'h0: return 3'b001;
            4'h1: return {g, 2'b10};
            4'h5: return {1'b0, ~g, 1'b0};
            4'h9: return live ? {av, 2'b10} : {g, 2'b10};
            4'hd: return live ? {1'b0, ~av, 1'b0} : {1'b0, ~g, 1'b0};
            default: return 3'b000;
        endcase
    endfunction : padf
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    // expectation for the coming edge, from the inputs now applied
    task automatic push_exp;
        logic own4, own2, slv, mst, t4;
        logic [2:0] r [5];
        papf_exp_t x;
        own4 = !remap[7] && ccer2[3];
        own2 = !remap[5] && ccer2[1];
        slv = mode == PAPF_SC_SPI && !spicfg[4];
        mst = mode == PAPF_SC_SPI && spicfg[4];
        t4 = trc[0] && trc[1];
        r[0] = (cfgl[11:8] == 4'h9) ? padf(4'h9, own4 || mst, own4 ? src[0] : src[4], gpio[0])
            : padf(cfgl[11:8], !own4 && mode == PAPF_SC_TWI, src[3], gpio[0]);
        r[1] = padf(cfgl[15:12], own2 || trc[0], own2 ? src[1] : src[5], gpio[1]);
        r[2] = padf(cfgh[3:0], t4 || (!trc[0] && trc[2]), t4 ? src[6] : src[8], gpio[2]);
        r[3] = padf(cfgh[7:4], t4 || (!trc[0] && trc[2]), t4 ? src[7] : src[9], gpio[3]);
        r[4] = padf(cfgh[11:8], ccer1[2], src[2], gpio[4]);
        for (int i = 0; i < 5; i++) {x.p.out[i], x.p.oe[i], x.p.analog[i]} = r[i];
        x.p.analog[4] = 1'b0;
        x.p.analog[1:0] = 2'h0;
        x.m = 5'h1f;
        if (slv && cfgl[11] && cfgl[8]) x.m[0] = 1'b0;
        if (slv && cfgl[15] && cfgl[12]) x.m[1] = 1'b0;
        x.c = '{tim2_ch4: remap[7] ? pb4 : pa_in[0], tim2_ch2: remap[5] ? pb2 : pa_in[1],
            tim1_ch3: pa_in[4], twi_clk: mode == PAPF_SC_TWI ? pa_in[0] : 1'b1,
            spi_clk: slv ? pa_in[0] : 1'b0, ssel_n: slv ? pa_in[1] : 1'b1, gpio: pa_in};
        x.pb = {remap[7] & ccer2[3], remap[5] & ccer2[1]};
        // strap follows the pad while external reset is low and one edge after
        if (!ext_n || prev_low) fmb_e = !pa_in[3];
        prev_low = !ext_n;
        if (sys_rst) begin
            x.p = PAPF_PADS_RST;
            x.c = PAPF_CAPS_RST;
            x.pb = 2'h0;
            fmb_e = 1'b0;
            prev_low = 1'b0;
        end
        x.fmb = fmb_e;
        q.push_back(x);
    endtask : push_exp
    // one cycle of random stimulus; strap mode holds pin five as an input
    task automatic step(input logic rst, input logic ext, input logic sm, input logic s);
        @(negedge clk);
        sys_rst = rst;
        ext_n = ext;
        {remap, spicfg, ccer2, ccer1, mode, trc} = 29'($urandom);
        {src, gpio, drv_en, drv_val, pb2, pb4} = 27'($urandom);
        cfgl = {CODES_B[$urandom % 6], CODES_A[$urandom % 6], 8'($urandom)};
        cfgh = {4'($urandom), CODES_B[$urandom % 6], CODES_B[$urandom % 6],
            CODES_B[$urandom % 6]};
        if (sm) begin
            cfgh[7:4] = 4'h4;
            drv_en[3] = 1'b1;
            drv_val[3] = s;
        end
        #1 push_exp();
    endtask : step
    // result watcher: oldest note against what the outputs show
    always @(posedge clk) begin
        if (q.size() > 0) begin
            e = q.pop_front();
            #1;
            chk({1'b0, pads.out & pads.oe & e.m, pads.oe & e.m, pads.analog},
                {1'b0, e.p.out & e.p.oe & e.m, e.p.oe & e.m, e.p.analog});
            chk(16'(caps), 16'(e.c));
            chk(16'(pbo), 16'(e.pb));
            chk(16'(fmb), 16'(e.fmb));
        end
    end
    // hang guard: the sequence needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(32'h04319f0b));
        repeat (10) step(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (600) step(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test random_mux done");
        repeat (4) step(1'b0, 1'b0, 1'b1, 1'b0);
        repeat (3) step(1'b0, 1'b1, 1'b1, 1'b0);
        repeat (20) step(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (4) step(1'b0, 1'b0, 1'b1, 1'b1);
        repeat (3) step(1'b0, 1'b1, 1'b1, 1'b1);
        repeat (20) step(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test boot_strap done");
        repeat (2) step(1'b1, 1'b1, 1'b0, 1'b0);
        repeat (20) step(1'b0, 1'b1, 1'b0, 1'b0);
        $display("test mid_reset done");
        repeat (2) @(negedge clk);
        conclude();
    end
endmodule : test_papf_pin_mux
